/* File: hdl/probe_pkg.sv */
// constants and types shared by the touch probe latch
package probe_pkg;
  localparam logic [15:0] IDX_CONTROL = 16'h60B8;
  localparam logic [15:0] IDX_STATUS = 16'h60B9;
  localparam logic [15:0] IDX_ONE_RISE = 16'h60BA;
  localparam logic [15:0] IDX_ONE_FALL = 16'h60BB;
  localparam logic [15:0] IDX_TWO_RISE = 16'h60BC;
  localparam logic [15:0] IDX_TWO_FALL = 16'h60BD;
  // control / status field positions within one channel byte
  localparam int CTL_ENABLE = 0;
  localparam int CTL_CONTINUOUS = 1;
  localparam int CTL_ZERO_SRC = 2;
  localparam int CTL_RISE_EN = 4;
  localparam int CTL_FALL_EN = 5;
  localparam int STS_ENABLED = 0;
  localparam int STS_RISE_STORED = 1;
  localparam int STS_FALL_STORED = 2;
  localparam int STS_COUNT_LO = 6;
  localparam int CHAN_BYTE = 8;
  localparam logic [3:0] SEL_PROBE_ONE = 4'h8;
  localparam logic [3:0] SEL_PROBE_TWO = 4'h9;
  localparam logic [3:0] PIN_A_SEL_RESET = 4'h8;
  localparam logic [3:0] PIN_B_SEL_RESET = 4'h9;
  localparam logic [7:0] FILTER_MAX = 8'hC8;
  localparam logic [7:0] FILTER_RESET = 8'h14;
  localparam int FILTER_UNIT_NS = 10;
  localparam int CLK_PERIOD_NS = 20;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  typedef enum {ACC_IDLE, ACC_ANSWER} access_state_t;
endpackage : probe_pkg

/* File: hdl/probe_filter_if.sv */
// carries the raw pin level into the filter and the settled level back
interface probe_filter_if;
  logic raw;
  logic settled;
  modport filter (input raw, output settled);
  modport user (output raw, input settled);
endinterface : probe_filter_if

/* File: hdl/probe_filter.sv */
// input glitch filter: a level passes only after it held for the filter time
module probe_filter
  import probe_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] filter_time_in,
  probe_filter_if.filter sig
);
  typedef struct packed {
    logic [8:0] count;
    logic level;
  } filt_state_t;

  filt_state_t st_r;
  filt_state_t st_nxt;
  logic [8:0] limit;

  // filter time is in 10 ns units; counted in whole clocks, rounded up
  always_comb begin
    // worked at 12 bits so the 200-unit ceiling (2000 ns) cannot wrap
    limit = 9'((12'(filter_time_in) * 12'(FILTER_UNIT_NS) + 12'(CLK_PERIOD_NS - 1))
            / 12'(CLK_PERIOD_NS));
    st_nxt = st_r;
    if (sig.raw == st_r.level) begin
      st_nxt.count = '0;
    end else if (st_r.count + 9'h001 >= limit) begin
      st_nxt.level = sig.raw;
      st_nxt.count = '0;
    end else begin
      st_nxt.count = st_r.count + 9'h001;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sig.settled = st_r.level;
endmodule : probe_filter

/* File: hdl/touch_probe_position_latch.sv */
// two-channel touch probe position latch with object dictionary access
module touch_probe_position_latch
  import probe_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic assignable_pin_a_in,
  input wire logic assignable_pin_b_in,
  input wire logic encoder_zero_in,
  input wire logic [31:0] feedback_position_in,
  input wire logic [3:0] pin_a_function_select_in,
  input wire logic [3:0] pin_b_function_select_in,
  input wire logic pin_a_invert_in,
  input wire logic pin_b_invert_in,
  input wire logic [7:0] probe_filter_time_in,
  input wire logic od_read_in,
  input wire logic od_write_in,
  input wire logic [15:0] od_index_in,
  input wire logic [31:0] od_wdata_in,
  output logic [31:0] od_rdata_out,
  output logic od_ack_out,
  output logic od_error_out,
  output logic [15:0] probe_latch_status_out,
  output logic [1:0] probe_input_out
);
  typedef struct packed {
    logic [3:0] sel_a;
    logic [3:0] sel_b;
    logic [7:0] filter;
    logic [15:0] control;
    logic [15:0] status;
    logic [1:0] prev_trig;
    logic [1:0] prev_en;
    logic [1:0] rise_done;
    logic [1:0] fall_done;
    logic [31:0] one_rise;
    logic [31:0] one_fall;
    logic [31:0] two_rise;
    logic [31:0] two_fall;
    logic [1:0] probe_in;
    logic [31:0] rdata;
    logic ack;
    logic err;
    logic started;
    access_state_t acc;
  } latch_state_t;

  latch_state_t st_r;
  latch_state_t st_nxt;
  logic pin_a_active;
  logic pin_b_active;
  logic [1:0] probe_level;
  logic [1:0] trig;
  logic [31:0] pos_nxt [4];

  probe_filter_if filt_a ();
  probe_filter_if filt_b ();

  // filter setting is only taken once after reset, as the real unit does
  probe_filter u_filter_a (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .filter_time_in(st_r.filter),
    .sig(filt_a.filter)
  );
  probe_filter u_filter_b (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .filter_time_in(st_r.filter),
    .sig(filt_b.filter)
  );

  // raw pins are active low unless inverted
  assign filt_a.raw = assignable_pin_a_in ^ ~pin_a_invert_in;
  assign filt_b.raw = assignable_pin_b_in ^ ~pin_b_invert_in;
  assign pin_a_active = filt_a.settled;
  assign pin_b_active = filt_b.settled;

  always_comb begin
    // a selector of 0..7 hands the pin to other functions
    probe_level[0] = (st_r.sel_a == SEL_PROBE_ONE && pin_a_active)
                   | (st_r.sel_b == SEL_PROBE_ONE && pin_b_active);
    probe_level[1] = (st_r.sel_a == SEL_PROBE_TWO && pin_a_active)
                   | (st_r.sel_b == SEL_PROBE_TWO && pin_b_active);
  end

  always_comb begin
    logic [7:0] ctl;
    logic en;
    logic rise_ev;
    logic fall_ev;
    logic [1:0] cnt;
    ctl = '0;
    en = 1'b0;
    rise_ev = 1'b0;
    fall_ev = 1'b0;
    cnt = '0;
    st_nxt = st_r;
    pos_nxt[0] = st_r.one_rise;
    pos_nxt[1] = st_r.one_fall;
    pos_nxt[2] = st_r.two_rise;
    pos_nxt[3] = st_r.two_fall;
    st_nxt.probe_in = probe_level;
    if (!st_r.started) begin
      st_nxt.started = 1'b1;
      st_nxt.sel_a = pin_a_function_select_in;
      st_nxt.sel_b = pin_b_function_select_in;
      st_nxt.filter = (probe_filter_time_in > FILTER_MAX) ? FILTER_MAX
                      : probe_filter_time_in;
    end
    for (int c = 0; c < 2; c++) begin
      ctl = st_r.control[c*CHAN_BYTE +: CHAN_BYTE];
      en = ctl[CTL_ENABLE];
      trig[c] = ctl[CTL_ZERO_SRC] ? encoder_zero_in : st_r.probe_in[c];
      st_nxt.prev_trig[c] = trig[c];
      st_nxt.prev_en[c] = en;
      rise_ev = en && ctl[CTL_RISE_EN] && trig[c] && !st_r.prev_trig[c];
      fall_ev = en && ctl[CTL_FALL_EN] && !trig[c] && st_r.prev_trig[c];
      if (!ctl[CTL_CONTINUOUS]) begin
        rise_ev = rise_ev && !st_r.rise_done[c];
        fall_ev = fall_ev && !st_r.fall_done[c];
      end
      cnt = st_r.status[c*CHAN_BYTE+STS_COUNT_LO +: 2];
      if (!en) begin
        // disabling re-arms the channel and clears its flags
        st_nxt.rise_done[c] = 1'b0;
        st_nxt.fall_done[c] = 1'b0;
        st_nxt.status[c*CHAN_BYTE +: CHAN_BYTE] = '0;
      end else begin
        st_nxt.status[c*CHAN_BYTE+STS_ENABLED] = 1'b1;
        if (!st_r.prev_en[c]) begin
          st_nxt.status[c*CHAN_BYTE+STS_RISE_STORED] = 1'b0;
          st_nxt.status[c*CHAN_BYTE+STS_FALL_STORED] = 1'b0;
        end
        if (rise_ev) begin
          pos_nxt[2*c] = feedback_position_in;
          st_nxt.rise_done[c] = 1'b1;
          st_nxt.status[c*CHAN_BYTE+STS_RISE_STORED] = 1'b1;
        end
        if (fall_ev) begin
          pos_nxt[2*c+1] = feedback_position_in;
          st_nxt.fall_done[c] = 1'b1;
          st_nxt.status[c*CHAN_BYTE+STS_FALL_STORED] = 1'b1;
        end
        if (ctl[CTL_CONTINUOUS] && (rise_ev || fall_ev)) begin
          st_nxt.status[c*CHAN_BYTE+STS_COUNT_LO +: 2] = cnt + 2'h1;
        end
      end
    end
    // positions change only on capture
    st_nxt.one_rise = pos_nxt[0];
    st_nxt.one_fall = pos_nxt[1];
    st_nxt.two_rise = pos_nxt[2];
    st_nxt.two_fall = pos_nxt[3];
    st_nxt.ack = 1'b0;
    st_nxt.err = 1'b0;
    st_nxt.acc = ACC_IDLE;
    if (st_r.acc == ACC_IDLE && (od_read_in || od_write_in)) begin
      st_nxt.ack = 1'b1;
      st_nxt.acc = ACC_ANSWER;
      st_nxt.rdata = '0;
      case (od_index_in)
        IDX_CONTROL: begin
          if (od_write_in) begin
            st_nxt.control = od_wdata_in[15:0];
          end
          st_nxt.rdata = {16'h0000, st_r.control};
        end
        IDX_STATUS: begin
          st_nxt.err = od_write_in;
          st_nxt.rdata = {16'h0000, st_r.status};
        end
        IDX_ONE_RISE: begin
          st_nxt.err = od_write_in;
          st_nxt.rdata = st_r.one_rise;
        end
        IDX_ONE_FALL: begin
          st_nxt.err = od_write_in;
          st_nxt.rdata = st_r.one_fall;
        end
        IDX_TWO_RISE: begin
          st_nxt.err = od_write_in;
          st_nxt.rdata = st_r.two_rise;
        end
        IDX_TWO_FALL: begin
          st_nxt.err = od_write_in;
          st_nxt.rdata = st_r.two_fall;
        end
        default: begin
          st_nxt.err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= '0;
      st_r.sel_a <= PIN_A_SEL_RESET;
      st_r.sel_b <= PIN_B_SEL_RESET;
      st_r.filter <= FILTER_RESET;
      st_r.control <= CONTROL_RESET;
      st_r.acc <= ACC_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign od_rdata_out = st_r.rdata;
  assign od_ack_out = st_r.ack;
  assign od_error_out = st_r.err;
  assign probe_latch_status_out = st_r.status;
  assign probe_input_out = st_r.probe_in;

  a_enable_flag: assert property (@(posedge clk_in) disable iff (!rstn_in)
    st_r.control[CTL_ENABLE] |=> st_r.status[STS_ENABLED])
    else $error("enable flag not shown");
  a_two_enable: assert property (@(posedge clk_in) disable iff (!rstn_in)
    st_r.control[CHAN_BYTE+CTL_ENABLE] |=> st_r.status[CHAN_BYTE+STS_ENABLED])
    else $error("channel two enable flag not shown");
  a_disabled_clear: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !st_r.control[CHAN_BYTE+CTL_ENABLE] |=> st_r.status[15:8] == 8'h00)
    else $error("disabled channel flags not clear");
  a_one_disabled: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !st_r.control[CTL_ENABLE] |=> st_r.status[7:0] == 8'h00)
    else $error("disabled channel one flags not clear");

  // capture and hold of the latched positions
  a_rise_capture: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (st_r.control[CTL_ENABLE] && st_r.control[CTL_RISE_EN] && !st_r.control[CTL_ZERO_SRC]
     && st_r.control[CTL_CONTINUOUS] && st_r.probe_in[0] && !st_r.prev_trig[0]
     && $stable(st_r.control))
    |=> st_r.one_rise == $past(feedback_position_in) && st_r.status[STS_RISE_STORED])
    else $error("rising capture missed");
  a_fall_stored: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $rose(st_r.status[STS_FALL_STORED]) |-> $past(st_r.prev_trig[0]))
    else $error("falling flag without edge");
  a_two_rise_stored: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $rose(st_r.status[CHAN_BYTE+STS_RISE_STORED]) |-> !$past(st_r.prev_trig[1]))
    else $error("channel two rising flag without edge");
  a_count_step: assert property (@(posedge clk_in) disable iff (!rstn_in)
    st_r.status[0] && $past(st_r.status[0]) && $changed(st_r.status[7:6])
    |-> st_r.status[7:6] == 2'($past(st_r.status[7:6]) + 2'h1))
    else $error("channel one count not cyclic");
  a_count_single: assert property (@(posedge clk_in) disable iff (!rstn_in)
    st_r.control[CTL_ENABLE] && !st_r.control[CTL_CONTINUOUS] && st_r.status[STS_ENABLED]
    |=> $stable(st_r.status[7:6]))
    else $error("channel one count moved in single mode");
  a_count_two: assert property (@(posedge clk_in) disable iff (!rstn_in)
    st_r.status[8] && $past(st_r.status[8]) && $changed(st_r.status[15:14])
    |-> st_r.status[15:14] == 2'($past(st_r.status[15:14]) + 2'h1))
    else $error("channel two count not cyclic");
  a_single_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
    st_r.control[CTL_ENABLE] && !st_r.control[CTL_CONTINUOUS] && st_r.rise_done[0]
    |=> $stable(st_r.one_rise))
    else $error("single mode captured twice");
  a_one_rise_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $changed(st_r.one_rise)
    |-> $past(st_r.control[CTL_ENABLE]) && $past(st_r.control[CTL_RISE_EN]))
    else $error("channel one rise value changed without capture");
  a_one_fall_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $changed(st_r.one_fall)
    |-> $past(st_r.control[CTL_ENABLE]) && $past(st_r.control[CTL_FALL_EN]))
    else $error("channel one fall value changed without capture");
  a_two_rise_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $changed(st_r.two_rise)
    |-> $past(st_r.control[CHAN_BYTE+CTL_ENABLE]) && $past(st_r.control[CHAN_BYTE+CTL_RISE_EN]))
    else $error("channel two rise value changed without capture");
  a_two_fall_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $changed(st_r.two_fall) |-> $rose(st_r.fall_done[1]) || st_r.control[CHAN_BYTE+1])
    else $error("channel two fall value changed without capture");

  // pin routing into the probe inputs
  a_route_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    st_r.sel_a == SEL_PROBE_ONE && st_r.sel_b != SEL_PROBE_ONE
    |=> st_r.probe_in[0] == $past(pin_a_active))
    else $error("pin a not routed to probe input one");
  a_route_swap: assert property (@(posedge clk_in) disable iff (!rstn_in)
    st_r.sel_a == SEL_PROBE_TWO && st_r.sel_b != SEL_PROBE_TWO
    |=> st_r.probe_in[1] == $past(pin_a_active))
    else $error("pin a not routed to probe input two");

  // object access answer
  a_ro_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (st_r.acc == ACC_IDLE && od_write_in && od_index_in == IDX_ONE_RISE)
    |=> od_ack_out && od_error_out)
    else $error("write to read-only object accepted");
  a_ack_pulse: assert property (@(posedge clk_in) disable iff (!rstn_in)
    od_ack_out |=> !od_ack_out)
    else $error("answer longer than one cycle");
  a_error_with_ack: assert property (@(posedge clk_in) disable iff (!rstn_in)
    od_error_out |-> od_ack_out)
    else $error("error shown without answer");
endmodule : touch_probe_position_latch

/* File: sim/probe_sensor_model.sv */
// stand-in for the probe contacts and the encoder zero pulse
module probe_sensor_model (
  input wire logic clk_in,
  input wire logic touch_a_in,
  input wire logic touch_b_in,
  input wire logic zero_req_in,
  output logic pin_a_out,
  output logic pin_b_out,
  output logic zero_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic req_r = 1'b0;
  logic zero_r = 1'b0;
  // contacts pull the line low while touched
  assign pin_a_out = ~touch_a_in;
  assign pin_b_out = ~touch_b_in;
  assign zero_out = zero_r;
  // zero mark is a single clock wide, so it cannot be seen twice
  always @(posedge clk_in) begin
    req_r <= zero_req_in;
    zero_r <= zero_req_in & ~req_r;
  end
endmodule : probe_sensor_model

/* File: sim/touch_probe_position_latch_bench.sv */
// self-checking bench for the touch probe position latch
module touch_probe_position_latch_bench;
  import probe_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic touch_a = 1'b0;
  logic touch_b = 1'b0;
  logic zero_req = 1'b0;
  logic pin_a, pin_b, zero, inv_a, inv_b, od_read, od_write, od_ack, od_error, er;
  logic [3:0] sel_a = PIN_A_SEL_RESET;
  logic [3:0] sel_b = PIN_B_SEL_RESET;
  logic [15:0] od_index, status;
  logic [31:0] pos, od_wdata, od_rdata, rd;
  logic [1:0] probe_in;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;

  probe_sensor_model sensor (.clk_in(clk_in), .touch_a_in(touch_a), .touch_b_in(touch_b),
    .zero_req_in(zero_req), .pin_a_out(pin_a), .pin_b_out(pin_b), .zero_out(zero));
  touch_probe_position_latch DUT (.clk_in(clk_in), .rstn_in(rstn_in),
    .assignable_pin_a_in(pin_a), .assignable_pin_b_in(pin_b), .encoder_zero_in(zero),
    .feedback_position_in(pos), .pin_a_function_select_in(sel_a),
    .pin_b_function_select_in(sel_b), .pin_a_invert_in(inv_a), .pin_b_invert_in(inv_b),
    .probe_filter_time_in(FILTER_RESET), .od_read_in(od_read), .od_write_in(od_write),
    .od_index_in(od_index), .od_wdata_in(od_wdata), .od_rdata_out(od_rdata),
    .od_ack_out(od_ack), .od_error_out(od_error), .probe_latch_status_out(status),
    .probe_input_out(probe_in));

  always #10 clk_in = ~clk_in;

  // whole run needs about 800 cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task report_and_stop;
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word

  task cmp_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_bit

  task cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc

  task do_reset(input logic [3:0] a, input logic [3:0] b);
    @(negedge clk_in);
    rstn_in = 1'b0;
    sel_a = a;
    sel_b = b;
    cyc(5);
    rstn_in = 1'b1;
    cyc(2);
  endtask : do_reset

  // request stands over the answer edge, which ignores it; answer taken while ack stands
  task od(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    @(negedge clk_in);
    od_read = ~wr;
    od_write = wr;
    od_index = idx;
    od_wdata = wd;
    @(negedge clk_in);
    cmp_bit("od_ack", 1'b1, od_ack);
    rd = od_rdata;
    er = od_error;
    @(negedge clk_in);
    od_read = 1'b0;
    od_write = 1'b0;
  endtask : od

  task rd_chk(input string what, input logic [15:0] idx, input logic [31:0] exp);
    od(1'b0, idx, 32'h0);
    cmp_word(what, exp, rd);
    cmp_bit("od_error", 1'b0, er);
  endtask : rd_chk

  task sts(input logic [15:0] mask, input logic [15:0] exp);
    cmp_word("status", {16'h0000, exp}, {16'h0000, status & mask});
  endtask : sts

  // filter of 20 units is 10 cycles, plus a few cycles of capture latency
  localparam int TOUCH_A = 0;
  localparam int TOUCH_B = 1;
  localparam int ZERO_REQ = 2;
  localparam int INVERT_A = 3;
  // the line must change now, not when the task returns
  task stim(input int which, input logic v, input logic [31:0] p);
    pos = p;
    case (which)
      TOUCH_A: touch_a = v;
      TOUCH_B: touch_b = v;
      ZERO_REQ: zero_req = v;
      default: inv_a = v;
    endcase
    cyc(30);
  endtask : stim

  task sc_single_one;
    sts(16'hFFFF, 16'h0000);
    od(1'b1, IDX_CONTROL, 32'h0000_0031);
    sts(16'hFFFF, 16'h0001);
    stim(TOUCH_A, 1'b1, 32'h1234_5678);
    cmp_bit("probe_input_one", 1'b1, probe_in[0]);
    sts(16'h003F, 16'h0003);
    stim(TOUCH_A, 1'b0, 32'hFFFF_FFFB);
    sts(16'h003F, 16'h0007);
    stim(TOUCH_A, 1'b1, 32'h0000_0999);
    stim(TOUCH_A, 1'b0, 32'h0000_0AAA);
    rd_chk("one_rise", IDX_ONE_RISE, 32'h1234_5678);
    rd_chk("one_fall", IDX_ONE_FALL, 32'hFFFF_FFFB);
    od(1'b1, IDX_CONTROL, 32'h0);
    sts(16'hFFFF, 16'h0000);
  endtask : sc_single_one

  task sc_cont_two;
    od(1'b1, IDX_CONTROL, 32'h0000_3300);
    for (int i = 0; i < 3; i++) begin
      stim(TOUCH_B, 1'b1, 32'h100 + i);
      stim(TOUCH_B, 1'b0, 32'h200 + i);
    end
    pos = 32'h5555_0000;
    sts(16'hFFFF, 16'h8700);
    rd_chk("two_rise", IDX_TWO_RISE, 32'h0000_0102);
    rd_chk("two_fall", IDX_TWO_FALL, 32'h0000_0202);
    od(1'b1, IDX_CONTROL, 32'h0);
  endtask : sc_cont_two

  task sc_zero_src;
    od(1'b1, IDX_CONTROL, 32'h0000_0015);
    stim(TOUCH_A, 1'b1, 32'h0000_0111);
    stim(TOUCH_A, 1'b0, 32'h0000_0222);
    sts(16'h003F, 16'h0001);
    stim(ZERO_REQ, 1'b1, 32'h0000_ABCD);
    stim(ZERO_REQ, 1'b0, 32'h0000_0333);
    sts(16'h003F, 16'h0003);
    rd_chk("zero_rise", IDX_ONE_RISE, 32'h0000_ABCD);
    od(1'b1, IDX_CONTROL, 32'h0);
  endtask : sc_zero_src

  task sc_invert;
    od(1'b1, IDX_CONTROL, 32'h0000_0013);
    stim(INVERT_A, 1'b1, 32'h0000_0777);
    sts(16'hFFFF, 16'h0043);
    stim(INVERT_A, 1'b0, 32'h0000_0888);
    sts(16'hFFFF, 16'h0043);
    for (int i = 0; i < 3; i++) begin
      stim(INVERT_A, 1'b1, 32'h0000_0900 + i);
      stim(INVERT_A, 1'b0, 32'h0);
    end
    sts(16'hFFFF, 16'h0003);
    rd_chk("one_rise", IDX_ONE_RISE, 32'h0000_0902);
    od(1'b1, IDX_CONTROL, 32'h0);
  endtask : sc_invert

  task sc_refuse;
    od(1'b1, IDX_CONTROL, 32'h0000_3031);
    rd_chk("control", IDX_CONTROL, 32'h0000_3031);
    od(1'b1, IDX_STATUS, 32'h0000_FFFF);
    cmp_bit("od_error", 1'b1, er);
    od(1'b1, IDX_TWO_FALL, 32'h0000_0001);
    cmp_bit("od_error", 1'b1, er);
    od(1'b1, IDX_ONE_RISE, 32'h0000_0001);
    cmp_bit("od_error", 1'b1, er);
    rd_chk("one_rise", IDX_ONE_RISE, 32'h0000_0902);
    od(1'b0, 16'h1234, 32'h0);
    cmp_bit("od_error", 1'b1, er);
    sts(16'hFFFF, 16'h0001);
    od(1'b1, IDX_CONTROL, 32'h0);
  endtask : sc_refuse

  task sc_pin_swap;
    do_reset(SEL_PROBE_TWO, SEL_PROBE_ONE);
    od(1'b1, IDX_CONTROL, 32'h0000_1111);
    stim(TOUCH_A, 1'b1, 32'h0000_4444);
    cmp_word("probe_inputs", 32'h2, {30'h0, probe_in});
    sts(16'h3F3F, 16'h0301);
    rd_chk("two_rise", IDX_TWO_RISE, 32'h0000_4444);
    // 20 units of 10 ns need 10 steady clocks, then one more to register
    touch_b = 1'b1;
    cyc(10);
    cmp_bit("filter_early", 1'b0, probe_in[0]);
    cyc(1);
    cmp_bit("filter_late", 1'b1, probe_in[0]);
  endtask : sc_pin_swap

  initial begin
    inv_a = 1'b0;
    inv_b = 1'b0;
    od_read = 1'b0;
    od_write = 1'b0;
    od_index = 16'h0000;
    od_wdata = 32'h0;
    pos = 32'h0;
    do_reset(PIN_A_SEL_RESET, PIN_B_SEL_RESET);
    sc_single_one();
    sc_cont_two();
    sc_zero_src();
    sc_invert();
    sc_refuse();
    sc_pin_swap();
    report_and_stop();
  end
endmodule : touch_probe_position_latch_bench
